//--- src/csd_defines.svh
// Offsets, field positions, reset values and timing counts of the setup decoder
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

// Register word offsets (byte addresses)
`define CSD_ADDR_KEYSET   4'h0
`define CSD_ADDR_DISP     4'h4
`define CSD_ADDR_STATUS   4'h8
`define CSD_ADDR_ACTIVE   4'hc

// Field widths and positions
`define CSD_SET_W         11
`define CSD_ST_CAP_LSB    0
`define CSD_ST_DONE_BIT   8
`define CSD_ST_SWEN_BIT   9
`define CSD_ST_CFG_LSB    10
`define CSD_ST_SEL_BIT    13

// Reset values
`define CSD_KEYSET_RST    11'h000
`define CSD_DISP_RST      2'h0

// Display selection codes
`define CSD_DISP_TOTAL    2'h1
`define CSD_DISP_BATCH    2'h2

// Clock rate and printed times
`define CSD_CLK_HZ        40000000
`define CSD_HOLD_MS       1000
`define CSD_SHOT_LONG_MS  500
`define CSD_SHOT_SHORT_MS 50
`define CSD_RST_LONG_MS   20
`define CSD_RST_SHORT_MS  1

// Cycle counts derived from the times above
`define CSD_HOLD_CYC       (`CSD_CLK_HZ / 1000 * `CSD_HOLD_MS)
`define CSD_SHOT_LONG_CYC  (`CSD_CLK_HZ / 1000 * `CSD_SHOT_LONG_MS)
`define CSD_SHOT_SHORT_CYC (`CSD_CLK_HZ / 1000 * `CSD_SHOT_SHORT_MS)
`define CSD_RST_LONG_CYC   (`CSD_CLK_HZ / 1000 * `CSD_RST_LONG_MS)
`define CSD_RST_SHORT_CYC  (`CSD_CLK_HZ / 1000 * `CSD_RST_SHORT_MS)

// Cycles after reset release before the switch bank is captured
`define CSD_SETTLE        3'h4

`endif

//--- src/csd_pkg.sv
// Types shared by the setup decoder files
package csd_pkg;

  // Counter configuration, cyclic selection order
  typedef enum logic [2:0] {
    CSD_CFG_ONE   = 3'b000,
    CSD_CFG_TWO   = 3'b001,
    CSD_CFG_TOTAL = 3'b010,
    CSD_CFG_BATCH = 3'b011,
    CSD_CFG_DUAL  = 3'b100,
    CSD_CFG_TWIN  = 3'b101,
    CSD_CFG_TACH  = 3'b110
  } csd_cfg_type;

  // Key sequence states
  typedef enum logic [2:0] {
    CSD_K_IDLE    = 3'b000,
    CSD_K_MODE    = 3'b001,
    CSD_K_QUAL    = 3'b010,
    CSD_K_SELECT  = 3'b011,
    CSD_K_BLOCKED = 3'b100
  } csd_key_state_type;

  // Rate-meter comparison styles
  typedef enum logic [1:0] {
    RATE_BAND_COMPARE       = 2'b00,
    RATE_WINDOW_COMPARE     = 2'b01,
    RATE_DUAL_UPPER_COMPARE = 2'b10,
    RATE_DUAL_LOWER_COMPARE = 2'b11
  } csd_cmp_type;

  // Decoded settings, most significant field first
  typedef struct packed {
    csd_cmp_type cmp;
    logic [1:0]  avg;
    logic        sourcing;
    logic        rst_short;
    logic        shot_short;
    logic [1:0]  style;
    logic        count_down;
    logic        rate_fast;
  } csd_set_type;

  // Operator inputs, all from pins
  typedef struct packed {
    logic       rst_in;
    logic       rst_key;
    logic       up1_key;
    logic       mode_key;
    logic [7:0] sw;
  } csd_pins_type;

endpackage

//--- src/csd_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module csd_sync #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // csd_sync

//--- src/csd_decoder.sv
// Setup switch decoder, configuration key sequence and indicators
// How it works
// - Switch positions 2-8 count only when position 1 is ON, else key settings.
// - Position 2 picks counting rate: OFF slow filtered, ON fast.
// - Position 3 picks direction: OFF increment, ON decrement.
// - Positions 4 and 5 pick one of four output styles.
// - Position 6 picks one-shot time: OFF long, ON short.
// - Position 7 picks reset pulse width: OFF long, ON short.
// - Position 8 picks input format: OFF sinking, ON sourcing.
// - All positions OFF means key-entered settings only.
// - Switches are sampled once after power-up only.
// - Mode held, then up key held one second, enters selection.
// - Up key pressed before mode key blocks the entry.
// - In selection, each up press steps to next supported configuration.
// - Reset configuration is single-stage, or two-stage on two-stage builds.
// - Reset indicator lit while reset input or reset key active.
// - Total indicator lit exactly while total value is displayed.
// - Batch indicator lit exactly while batch value is displayed.
// - Rate-meter rate from switch: slow filtered or fast.
// - Rate-meter averaging from switches: off, 2, 4 or 8.
// - Rate-meter comparison style from switches, four choices.
`timescale 1ns/1ps
`include "csd_defines.svh"
module csd_decoder #(
  parameter logic        TWO_STAGE      = 1'b0,
  parameter logic [25:0] HOLD_CYC       = 26'(`CSD_HOLD_CYC),
  parameter logic [24:0] SHOT_LONG_CYC  = 25'(`CSD_SHOT_LONG_CYC),
  parameter logic [24:0] SHOT_SHORT_CYC = 25'(`CSD_SHOT_SHORT_CYC),
  parameter logic [19:0] RST_LONG_CYC   = 20'(`CSD_RST_LONG_CYC),
  parameter logic [19:0] RST_SHORT_CYC  = 20'(`CSD_RST_SHORT_CYC)
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire csd_pkg::csd_pins_type pins,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output csd_pkg::csd_set_type     active_set,
  output csd_pkg::csd_cfg_type     cfg_sel,
  output logic                     cfg_selecting,
  output logic      [24:0]         shot_cyc,
  output logic      [19:0]         rst_filt_cyc,
  output logic                     reset_ind,
  output logic                     total_ind,
  output logic                     batch_ind
);
  import csd_pkg::*;

  csd_pins_type      pin_s;
  logic [7:0]        cap_reg;
  logic              cap_done_reg;
  logic [2:0]        settle_reg;
  csd_set_type       key_set_reg;
  logic [1:0]        disp_reg;
  csd_key_state_type kst_reg;
  csd_key_state_type kst_next;
  logic [25:0]       hold_reg;
  logic              up_prev_reg;
  logic              mode_prev_reg;
  logic              up_rise;
  logic              mode_rise;
  logic              sw_en;
  logic              tach;
  logic              wb_req;
  logic              wb_wr;
  logic [31:0]       rd_next;

  // Next configuration in the cyclic order this build supports
  function automatic csd_cfg_type next_cfg(input csd_cfg_type c, input logic two);
    csd_cfg_type n;
    n = (c == CSD_CFG_TACH) ? CSD_CFG_ONE : csd_cfg_type'(3'(c + 3'h1));
    if (!two && (n == CSD_CFG_TWO || n == CSD_CFG_TACH))
    begin
      n = (n == CSD_CFG_TWO) ? CSD_CFG_TOTAL : CSD_CFG_ONE;
    end
    return n;
  endfunction

  // Merge switch positions over key-entered settings
  function automatic csd_set_type decode(input logic [7:0] sw, input csd_set_type key,
                                         input logic en, input logic rate);
    csd_set_type s;
    s = key;
    if (en)
    begin
      s.rate_fast = sw[1];
      s.sourcing  = sw[7];
      if (rate)
      begin
        s.avg = sw[3:2];
        s.cmp = csd_cmp_type'(sw[5:4]);
      end
      else
      begin
        s.count_down = sw[2];
        s.style      = sw[4:3];
        s.shot_short = sw[5];
        s.rst_short  = sw[6];
      end
    end
    return s;
  endfunction

  // Pin inputs into the clock domain
  csd_sync #(
    .W ($bits(csd_pins_type))
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pins),
    .q     (pin_s)
  );

  // Switch bank caught once, after the synchroniser settles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_reg   <= 3'h0;
      cap_reg      <= 8'h00;
      cap_done_reg <= 1'b0;
    end
    else if (!cap_done_reg)
    begin
      settle_reg <= 3'(settle_reg + 3'h1);
      if (settle_reg == `CSD_SETTLE)
      begin
        cap_reg      <= pin_s.sw;
        cap_done_reg <= 1'b1;
      end
    end
  end

  assign sw_en = cap_done_reg & cap_reg[0];
  assign tach  = (cfg_sel == CSD_CFG_TACH);

  // Effective settings and derived timing counts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_set   <= csd_set_type'(`CSD_KEYSET_RST);
      shot_cyc     <= 25'h0;
      rst_filt_cyc <= 20'h0;
    end
    else
    begin
      active_set   <= decode(cap_reg, key_set_reg, sw_en, tach);
      shot_cyc     <= active_set.shot_short ? SHOT_SHORT_CYC : SHOT_LONG_CYC;
      rst_filt_cyc <= active_set.rst_short ? RST_SHORT_CYC : RST_LONG_CYC;
    end
  end

  // Key edges for stepping and leaving selection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_prev_reg   <= 1'b0;
      mode_prev_reg <= 1'b0;
    end
    else
    begin
      up_prev_reg   <= pin_s.up1_key;
      mode_prev_reg <= pin_s.mode_key;
    end
  end

  assign up_rise   = pin_s.up1_key & ~up_prev_reg;
  assign mode_rise = pin_s.mode_key & ~mode_prev_reg;

  // Key sequence next state
  always_comb
  begin
    kst_next = kst_reg;
    case (kst_reg)
      CSD_K_IDLE:
      begin
        if (pin_s.up1_key)
          kst_next = CSD_K_BLOCKED;
        else if (pin_s.mode_key)
          kst_next = CSD_K_MODE;
      end
      CSD_K_MODE:
      begin
        if (!pin_s.mode_key)
          kst_next = pin_s.up1_key ? CSD_K_BLOCKED : CSD_K_IDLE;
        else if (pin_s.up1_key)
          kst_next = CSD_K_QUAL;
      end
      CSD_K_QUAL:
      begin
        if (!pin_s.mode_key || !pin_s.up1_key)
          kst_next = CSD_K_BLOCKED;
        else if (hold_reg == HOLD_CYC - 26'h1)
          kst_next = CSD_K_SELECT;
      end
      CSD_K_SELECT:
      begin
        if (mode_rise)
          kst_next = CSD_K_BLOCKED;
      end
      CSD_K_BLOCKED:
      begin
        if (!pin_s.mode_key && !pin_s.up1_key)
          kst_next = CSD_K_IDLE;
      end
      default:
        kst_next = CSD_K_IDLE;
    endcase
  end

  // Key sequence state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      kst_reg <= CSD_K_IDLE;
    else
      kst_reg <= kst_next;
  end

  // One-second hold timer, cleared on any release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_reg <= 26'h0;
    else if (kst_reg == CSD_K_QUAL && pin_s.mode_key && pin_s.up1_key)
      hold_reg <= 26'(hold_reg + 26'h1);
    else
      hold_reg <= 26'h0;
  end

  // Configuration choice, stepped by the up key
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_sel <= CSD_CFG_ONE;
    else if (!cap_done_reg)
      cfg_sel <= TWO_STAGE ? CSD_CFG_TWO : CSD_CFG_ONE;
    else if (kst_reg == CSD_K_SELECT && up_rise)
      cfg_sel <= next_cfg(cfg_sel, TWO_STAGE);
  end

  // Indicators
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_ind     <= 1'b0;
      total_ind     <= 1'b0;
      batch_ind     <= 1'b0;
      cfg_selecting <= 1'b0;
    end
    else
    begin
      reset_ind     <= pin_s.rst_in | pin_s.rst_key;
      total_ind     <= (disp_reg == `CSD_DISP_TOTAL);
      batch_ind     <= (disp_reg == `CSD_DISP_BATCH);
      cfg_selecting <= (kst_next == CSD_K_SELECT);
    end
  end

  // Wishbone: ack one cycle after request, write on the acked edge
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & wb_we_i & wb_ack_o;

  always_comb
  begin
    rd_next = 32'h0;
    case (wb_adr_i)
      `CSD_ADDR_KEYSET: rd_next[`CSD_SET_W-1:0] = key_set_reg;
      `CSD_ADDR_DISP:   rd_next[1:0] = disp_reg;
      `CSD_ADDR_STATUS:
      begin
        rd_next[`CSD_ST_CAP_LSB +: 8] = cap_reg;
        rd_next[`CSD_ST_DONE_BIT]     = cap_done_reg;
        rd_next[`CSD_ST_SWEN_BIT]     = sw_en;
        rd_next[`CSD_ST_CFG_LSB +: 3] = cfg_sel;
        rd_next[`CSD_ST_SEL_BIT]      = cfg_selecting;
      end
      `CSD_ADDR_ACTIVE: rd_next[`CSD_SET_W-1:0] = active_set;
      default:          rd_next = 32'h0;
    endcase
  end

  // Bus answer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= rd_next;
    end
  end

  // Software registers with byte lanes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_set_reg <= csd_set_type'(`CSD_KEYSET_RST);
      disp_reg    <= `CSD_DISP_RST;
    end
    else if (wb_wr)
    begin
      if (wb_adr_i == `CSD_ADDR_KEYSET)
      begin
        if (wb_sel_i[0])
          key_set_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          key_set_reg[`CSD_SET_W-1:8] <= wb_dat_i[`CSD_SET_W-1:8];
      end
      if (wb_adr_i == `CSD_ADDR_DISP && wb_sel_i[0])
        disp_reg <= wb_dat_i[1:0];
    end
  end

  // Checks
  sw_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !sw_en |=> active_set == $past(key_set_reg))
    else $error("key settings not used with switch disabled");
  speed_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en |=> active_set.rate_fast == cap_reg[1])
    else $error("rate does not follow position 2");
  dir_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en && !tach |=> active_set.count_down == cap_reg[2])
    else $error("direction does not follow position 3");
  style_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en && !tach |=> active_set.style == {cap_reg[4], cap_reg[3]})
    else $error("output style wrong");
  shot_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en && !tach && $stable(cfg_sel) ##1 $stable(cfg_sel)
      |=> shot_cyc == (cap_reg[5] ? SHOT_SHORT_CYC : SHOT_LONG_CYC))
    else $error("one-shot count wrong");
  rst_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en && !tach && $stable(cfg_sel) ##1 $stable(cfg_sel)
      |=> rst_filt_cyc == (cap_reg[6] ? RST_SHORT_CYC : RST_LONG_CYC))
    else $error("reset width count wrong");
  in_format_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en |=> active_set.sourcing == cap_reg[7])
    else $error("input format wrong");
  cap_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_done_reg |=> $stable(cap_reg) && cap_done_reg)
    else $error("switch capture changed after power-up");
  entry_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    kst_reg == CSD_K_QUAL && kst_next == CSD_K_SELECT
      |-> hold_reg == HOLD_CYC - 26'h1 && pin_s.mode_key)
    else $error("selection entered without full hold");
  up_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    kst_reg == CSD_K_IDLE && pin_s.up1_key |=> kst_reg == CSD_K_BLOCKED)
    else $error("up-first press not blocked");
  cfg_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_done_reg && kst_reg == CSD_K_SELECT && up_rise
      |=> cfg_sel == next_cfg($past(cfg_sel), TWO_STAGE))
    else $error("configuration did not step");
  rst_lamp_a: assert property (@(posedge clk) disable iff (!rst_n)
    pin_s.rst_in || pin_s.rst_key |=> reset_ind)
    else $error("reset indicator dark");
  total_lamp_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 total_ind == ($past(disp_reg) == `CSD_DISP_TOTAL))
    else $error("total indicator wrong");
  batch_lamp_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 batch_ind == ($past(disp_reg) == `CSD_DISP_BATCH))
    else $error("batch indicator wrong");
  rate_avg_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en && tach |=> active_set.avg == cap_reg[3:2]
      && active_set.rate_fast == cap_reg[1])
    else $error("rate-meter averaging wrong");
  rate_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_en && tach |=> active_set.cmp == csd_cmp_type'(cap_reg[5:4]))
    else $error("rate-meter comparison wrong");

endmodule // csd_decoder

//--- tb/csd_operator.sv
// Operator model: setting switch bank and front-panel keys
`timescale 1ns/1ps
module csd_operator (
  input  wire logic             clk,
  output csd_pkg::csd_pins_type pins
);
  import csd_pkg::*;

  // Untouched bank and released keys at power-up
  initial pins = '0;

  // Switch levels change just after a clock edge
  task automatic set_sw(input logic [7:0] s);
    @(posedge clk);
    pins.sw <= s;
  endtask

  // Key and reset levels change just after a clock edge
  task automatic keys(input logic m, input logic u, input logic rk, input logic ri);
    @(posedge clk);
    pins.mode_key <= m;
    pins.up1_key  <= u;
    pins.rst_key  <= rk;
    pins.rst_in   <= ri;
  endtask

  // Mode key first, then up key held for the given cycles
  task automatic enter_select(input int hold);
    keys(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    keys(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (hold) @(posedge clk);
  endtask
endmodule // csd_operator

//--- tb/tb_top.sv
// Self-checking bench for the setup switch decoder
`timescale 1ns/1ps
module tb_top;
  import csd_pkg::*;

  localparam logic [24:0] SHOT_L = 25'd200;
  localparam logic [24:0] SHOT_S = 25'd20;
  localparam logic [19:0] RFLT_L = 20'd80;
  localparam logic [19:0] RFLT_S = 20'd4;

  logic          clk;
  logic          rst_n;
  logic          cyc;
  logic          stb;
  logic          we;
  logic [3:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat;
  logic [31:0]   rdat;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  csd_pins_type  pins;
  csd_set_type   active_set;
  csd_set_type   held;
  csd_cfg_type   cfg_sel;
  logic          cfg_selecting;
  logic [24:0]   shot_cyc;
  logic [19:0]   rst_filt_cyc;
  logic          reset_ind;
  logic          total_ind;
  logic          batch_ind;
  int            failures;
  int            num_checks;
  logic [7:0]    tbl [6] = '{8'h01, 8'h0b, 8'h13, 8'hff, 8'h65, 8'h99};

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  csd_operator u_op (.clk(clk), .pins(pins));

  csd_decoder #(
    .TWO_STAGE(1'b1), .HOLD_CYC(26'd20), .SHOT_LONG_CYC(SHOT_L),
    .SHOT_SHORT_CYC(SHOT_S), .RST_LONG_CYC(RFLT_L), .RST_SHORT_CYC(RFLT_S)
  ) uut (
    .clk(clk), .rst_n(rst_n), .pins(pins), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .active_set(active_set),
    .cfg_sel(cfg_sel), .cfg_selecting(cfg_selecting), .shot_cyc(shot_cyc),
    .rst_filt_cyc(rst_filt_cyc), .reset_ind(reset_ind), .total_ind(total_ind),
    .batch_ind(batch_ind)
  );

  // Verdict and end of run
  task automatic wrap_up();
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50)
    begin
      chk("wb_ack_o", 32'h0, 32'h1);
      wrap_up();
    end
  endtask

  // Bounded wait for the selection flag
  task automatic wait_sel(input logic e);
    int n;
    n = 0;
    while (cfg_selecting !== e && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk("cfg_selecting", 32'(cfg_selecting), 32'(e));
    if (n >= 40)
      wrap_up();
  endtask

  // Power cycle with a given switch bank
  task automatic do_reset(input logic [7:0] s);
    u_op.set_sw(s);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cycles(12);
  endtask

  // Settings expected from switches and key register
  function automatic csd_set_type exp_set(input logic [7:0] s, input logic tach,
                                          input logic [10:0] k);
    csd_set_type r;
    r = k;
    if (s[0])
    begin
      r.rate_fast = s[1];
      r.sourcing  = s[7];
      if (tach)
      begin
        r.avg = {s[3], s[2]};
        r.cmp = csd_cmp_type'({s[5], s[4]});
      end
      else
      begin
        r.count_down = s[2];
        r.style      = {s[4], s[3]};
        r.shot_short = s[5];
        r.rst_short  = s[6];
      end
    end
    return r;
  endfunction

  // Main sequence
  initial
  begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 4'h0; sel = 4'h0; wdat = 32'h0;
    failures = 0; num_checks = 0;
    do_reset(8'h00);
    chk("cfg_sel", 32'(cfg_sel), 32'(CSD_CFG_TWO));
    chk("active_set", 32'(active_set), 32'h0);
    wb_xfer(1'b0, 4'h8, 32'h0);
    chk("status_swen", 32'(rdat[9]), 32'h0);
    // Key-entered settings with position 1 OFF
    wb_xfer(1'b1, 4'h0, 32'h000005a5);
    wb_xfer(1'b1, 4'hc, 32'h0);
    wb_xfer(1'b0, 4'hc, 32'h0);
    chk("active_reg", rdat, 32'h5a5);
    chk("active_set", 32'(active_set), 32'h5a5);
    // Switch table, one power cycle each
    for (int i = 0; i < 6; i++)
    begin
      do_reset(tbl[i]);
      held = exp_set(tbl[i], 1'b0, 11'h0);
      chk("active_set", 32'(active_set), 32'(held));
      chk("shot_cyc", 32'(shot_cyc), 32'(held.shot_short ? SHOT_S : SHOT_L));
      chk("rst_filt_cyc", 32'(rst_filt_cyc), 32'(held.rst_short ? RFLT_S : RFLT_L));
      wb_xfer(1'b0, 4'h8, 32'h0);
      chk("status_sw", {24'h0, rdat[7:0]}, {24'h0, tbl[i]});
    end
    // Switch change while powered has no effect
    u_op.set_sw(8'h00);
    cycles(10);
    chk("active_set", 32'(active_set), 32'(held));
    // Reset indicator
    u_op.keys(1'b0, 1'b0, 1'b0, 1'b1);
    cycles(4);
    chk("reset_ind", 32'(reset_ind), 32'h1);
    u_op.keys(1'b0, 1'b0, 1'b1, 1'b0);
    cycles(4);
    chk("reset_ind", 32'(reset_ind), 32'h1);
    u_op.keys(1'b0, 1'b0, 1'b0, 1'b0);
    cycles(4);
    chk("reset_ind", 32'(reset_ind), 32'h0);
    // Display selection indicators
    for (int d = 2; d >= 0; d--)
    begin
      wb_xfer(1'b1, 4'h4, 32'(d));
      cycles(2);
      chk("total_ind", 32'(total_ind), 32'(d == 1));
      chk("batch_ind", 32'(batch_ind), 32'(d == 2));
    end
    do_reset(8'h9b);
    // Up key before mode key is refused
    u_op.keys(1'b0, 1'b1, 1'b0, 1'b0);
    u_op.keys(1'b1, 1'b1, 1'b0, 1'b0);
    cycles(40);
    chk("cfg_selecting", 32'(cfg_selecting), 32'h0);
    u_op.keys(1'b0, 1'b0, 1'b0, 1'b0);
    // Early release restarts the hold count
    u_op.enter_select(12);
    u_op.keys(1'b1, 1'b0, 1'b0, 1'b0);
    u_op.keys(1'b0, 1'b0, 1'b0, 1'b0);
    cycles(30);
    chk("cfg_selecting", 32'(cfg_selecting), 32'h0);
    u_op.enter_select(16);
    chk("cfg_selecting", 32'(cfg_selecting), 32'h0);
    wait_sel(1'b1);
    u_op.keys(1'b0, 1'b0, 1'b0, 1'b0);
    cycles(5);
    // Step through the whole cyclic order
    for (int i = 1; i <= 7; i++)
    begin
      u_op.keys(1'b0, 1'b1, 1'b0, 1'b0);
      cycles(5);
      u_op.keys(1'b0, 1'b0, 1'b0, 1'b0);
      cycles(5);
      chk("cfg_sel", 32'(cfg_sel), (i + 1) % 7);
      held = exp_set(8'h9b, cfg_sel === CSD_CFG_TACH, 11'h0);
      chk("active_set", 32'(active_set), 32'(held));
    end
    u_op.keys(1'b1, 1'b0, 1'b0, 1'b0);
    wait_sel(1'b0);
    wrap_up();
  end
endmodule // tb_top
